//--- rtl/direct_access_engine.sv
`timescale 1ns/1ps
`default_nettype none
module direct_access_engine
    import mbox_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // from the port logic
    direct_access_if.engine acc,
    // local bus master cycle
    output logic direct_access_range_req,
    output logic direct_access_range_write,
    output logic [LB_ADDR_W-1:0] direct_access_range_addr,
    output logic [MBOX_W-1:0] direct_access_range_wdata,
    input wire logic direct_access_range_ack,
    input wire logic [MBOX_W-1:0] direct_access_range_rdata
);
    // ----------------------------------------
    // single local bus cycle per start
    // ----------------------------------------
    // request stays up until the slave acks; no DMA queue behind it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            direct_access_range_req <= 1'b0;
        end else if (acc.start) begin
            direct_access_range_req <= 1'b1;
        end else if (direct_access_range_ack) begin
            direct_access_range_req <= 1'b0;
        end
    end

    // cycle attributes latched at start, held through the cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            direct_access_range_write <= 1'b0;
            direct_access_range_addr <= '0;
            direct_access_range_wdata <= '0;
        end else if (acc.start) begin
            direct_access_range_write <= acc.write;
            direct_access_range_addr <= acc.addr;
            direct_access_range_wdata <= acc.wdata;
        end
    end

    // completion pulse and captured read data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc.done <= 1'b0;
            acc.rdata <= '0;
        end else begin
            acc.done <= direct_access_range_req && direct_access_range_ack;
            if (direct_access_range_req && direct_access_range_ack && !direct_access_range_write) begin
                acc.rdata <= direct_access_range_rdata;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence seq_started;
        acc.start ##1 direct_access_range_req;
    endsequence
    sequence seq_held;
        $stable(direct_access_range_addr) && $stable(direct_access_range_write);
    endsequence

    pio_cycle_held_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        direct_access_range_req && !direct_access_range_ack |=> seq_held)
        else $error("local bus cycle attributes changed mid cycle");
    pio_one_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_started |=> (!direct_access_range_ack |-> direct_access_range_req))
        else $error("local bus request dropped before ack");
endmodule
`default_nettype wire

//--- rtl/direct_access_if.sv
`timescale 1ns/1ps
`default_nettype none
// one direct access handed from the port logic to the local bus engine
interface direct_access_if;
    import mbox_pkg::*;
    logic start;
    logic write;
    logic [LB_ADDR_W-1:0] addr;
    logic [MBOX_W-1:0] wdata;
    logic done;
    logic [MBOX_W-1:0] rdata;
    modport port (output start, output write, output addr, output wdata, input done, input rdata);
    modport engine (input start, input write, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

//--- rtl/local_bus_mailbox.sv
`timescale 1ns/1ps
`default_nettype none
module local_bus_mailbox
    import mbox_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // processor register port
    input wire logic cpu_req,
    input wire logic cpu_write,
    input wire logic [17:0] cpu_addr,
    input wire logic [31:0] cpu_wdata,
    output logic cpu_ready,
    output logic [31:0] cpu_rdata,
    // local bus slave read of the mailbox
    input wire logic lb_rd,
    input wire logic [LB_ADDR_W-1:0] lb_addr,
    output logic [MBOX_W-1:0] lb_rd_data,
    // local bus master cycle for the direct access range
    output logic direct_access_range_req,
    output logic direct_access_range_write,
    output logic [LB_ADDR_W-1:0] direct_access_range_addr,
    output logic [MBOX_W-1:0] direct_access_range_wdata,
    input wire logic direct_access_range_ack,
    input wire logic [MBOX_W-1:0] direct_access_range_rdata,
    // interrupt toward the local bus master
    output logic host_interrupt_line
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    port_state_t state_reg;
    logic [MBOX_W-1:0] host_to_cpu_mailbox_reg;
    logic [MBOX_W-1:0] cpu_to_host_mailbox_reg;
    logic [IRQ_W-1:0] local_bus_irq_status_reg;
    logic [IRQ_W-1:0] local_bus_irq_mask_reg;
    logic local_bus_irq_global_enable_reg;
    logic [31:0] local_bus_misc_config_reg;
    logic mbox_irq_pending_reg;
    logic [IRQ_W-1:0] status_next;
    logic take;
    logic take_wr;
    logic take_rd;
    logic host_mbox_rd;
    logic h2c_wr;
    logic c2h_wr;
    logic [31:0] reg_rdata;

    direct_access_if acc ();

    // register address match, used for both reads and writes
    function automatic logic hit(input logic [17:0] a, input logic [17:0] ofs);
        hit = (a[17:2] == ofs[17:2]);
    endfunction

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    // a request is taken only while idle; the master holds it until ready
    assign take = cpu_req && (state_reg == ST_IDLE) && !cpu_addr[DIRECT_SEL_BIT];
    assign take_wr = take && cpu_write;
    assign take_rd = take && !cpu_write;
    assign h2c_wr = take_wr && hit(cpu_addr, HOST_TO_CPU_MBOX_OFS);
    assign c2h_wr = take_wr && hit(cpu_addr, CPU_TO_HOST_MBOX_OFS);
    assign host_mbox_rd = lb_rd && (lb_addr == LB_MBOX_ADDR);
    assign cpu_ready = (state_reg == ST_REPLY);

    // read mux; unmapped addresses read as zero
    always_comb begin
        reg_rdata = 32'h00000000;
        if (hit(cpu_addr, HOST_TO_CPU_MBOX_OFS)) begin
            reg_rdata = {16'h0000, host_to_cpu_mailbox_reg};
        end else if (hit(cpu_addr, CPU_TO_HOST_MBOX_OFS)) begin
            reg_rdata = {16'h0000, cpu_to_host_mailbox_reg};
        end else if (hit(cpu_addr, IRQ_STATUS_OFS)) begin
            reg_rdata = {13'h0000, local_bus_irq_status_reg};
        end else if (hit(cpu_addr, IRQ_MASK_OFS)) begin
            reg_rdata = {13'h0000, local_bus_irq_mask_reg};
        end else if (hit(cpu_addr, IRQ_GLOBAL_EN_OFS)) begin
            reg_rdata = {31'h00000000, local_bus_irq_global_enable_reg};
        end else if (hit(cpu_addr, MISC_CONFIG_OFS)) begin
            reg_rdata = local_bus_misc_config_reg;
        end
    end

    // ----------------------------------------
    // processor port sequencing
    // ----------------------------------------
    // direct accesses wait for the local bus; register accesses answer next cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (cpu_req && cpu_addr[DIRECT_SEL_BIT]) begin
                        state_reg <= ST_DIRECT;
                    end else if (cpu_req) begin
                        state_reg <= ST_REPLY;
                    end
                end
                ST_DIRECT: begin
                    if (acc.done) begin
                        state_reg <= ST_REPLY;
                    end
                end
                ST_REPLY: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE; // unused code falls back to idle
                end
            endcase
        end
    end

    // start pulse and cycle attributes toward the engine
    assign acc.start = cpu_req && (state_reg == ST_IDLE) && cpu_addr[DIRECT_SEL_BIT];
    assign acc.write = cpu_write;
    assign acc.addr = cpu_addr[16:2];
    assign acc.wdata = cpu_wdata[MBOX_W-1:0];

    // answer data, from registers or from the local bus
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= 32'h00000000;
        end else if (take_rd) begin
            cpu_rdata <= reg_rdata;
        end else if (acc.done) begin
            cpu_rdata <= {16'h0000, acc.rdata};
        end
    end

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    // mailboxes hold 16 bits; writes to the reserved half are dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_to_cpu_mailbox_reg <= MBOX_RESET;
            cpu_to_host_mailbox_reg <= MBOX_RESET;
        end else begin
            if (h2c_wr) begin
                host_to_cpu_mailbox_reg <= cpu_wdata[MBOX_W-1:0];
            end
            if (c2h_wr) begin
                cpu_to_host_mailbox_reg <= cpu_wdata[MBOX_W-1:0];
            end
        end
    end

    // mask, global enable and misc config
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            local_bus_irq_mask_reg <= IRQ_RESET;
            local_bus_irq_global_enable_reg <= 1'b0;
            local_bus_misc_config_reg <= MISC_CONFIG_RESET;
        end else if (take_wr) begin
            if (hit(cpu_addr, IRQ_MASK_OFS)) begin
                local_bus_irq_mask_reg <= cpu_wdata[IRQ_W-1:0];
            end
            if (hit(cpu_addr, IRQ_GLOBAL_EN_OFS)) begin
                local_bus_irq_global_enable_reg <= cpu_wdata[0];
            end
            if (hit(cpu_addr, MISC_CONFIG_OFS)) begin
                local_bus_misc_config_reg <= cpu_wdata;
            end
        end
    end

    // ----------------------------------------
    // interrupt status
    // ----------------------------------------
    // write one to clear; a same-cycle event wins so it is never lost
    always_comb begin
        status_next = local_bus_irq_status_reg;
        if (take_wr && hit(cpu_addr, IRQ_STATUS_OFS)) begin
            status_next = status_next & ~cpu_wdata[IRQ_W-1:0];
        end
        if (h2c_wr || host_mbox_rd) begin
            status_next[ST_H2C_BIT] = 1'b1;
        end
        if (c2h_wr) begin
            status_next[ST_C2H_BIT] = 1'b1;
        end
    end

    // the mask takes no part in status updates
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            local_bus_irq_status_reg <= IRQ_RESET;
        end else begin
            local_bus_irq_status_reg <= status_next;
        end
    end

    // mailbox interrupt: set by a cpu write when enabled, cleared by a host read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mbox_irq_pending_reg <= 1'b0;
        end else if ((h2c_wr || c2h_wr) && local_bus_misc_config_reg[CFG_MBOX_IRQ_BIT]) begin
            mbox_irq_pending_reg <= 1'b1;
        end else if (host_mbox_rd) begin
            mbox_irq_pending_reg <= 1'b0;
        end
    end

    // host line from the pending mailbox interrupt and gated status
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_interrupt_line <= 1'b0;
        end else begin
            host_interrupt_line <= mbox_irq_pending_reg
                || (local_bus_irq_global_enable_reg
                && |(local_bus_irq_status_reg & local_bus_irq_mask_reg));
        end
    end

    // ----------------------------------------
    // local bus read of the mailbox
    // ----------------------------------------
    // other local bus addresses answer zero here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lb_rd_data <= '0;
        end else if (lb_rd) begin
            lb_rd_data <= host_mbox_rd ? host_to_cpu_mailbox_reg : '0;
        end
    end

    direct_access_engine u_engine (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .acc(acc),
        .direct_access_range_req(direct_access_range_req),
        .direct_access_range_write(direct_access_range_write),
        .direct_access_range_addr(direct_access_range_addr),
        .direct_access_range_wdata(direct_access_range_wdata),
        .direct_access_range_ack(direct_access_range_ack),
        .direct_access_range_rdata(direct_access_range_rdata)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence seq_cpu_mbox_rd;
        take_rd && hit(cpu_addr, HOST_TO_CPU_MBOX_OFS) && !lb_rd;
    endsequence
    sequence seq_direct_done;
        (state_reg == ST_DIRECT) && acc.done ##1 cpu_ready;
    endsequence

    mbox_read_pure_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_cpu_mbox_rd |=> $stable(local_bus_irq_status_reg) && $stable(mbox_irq_pending_reg))
        else $error("cpu mailbox read changed state");
    host_read_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        host_mbox_rd |=> lb_rd_data == $past(host_to_cpu_mailbox_reg))
        else $error("host mailbox read returned wrong data");
    write_irq_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        h2c_wr && local_bus_misc_config_reg[CFG_MBOX_IRQ_BIT] |=> ##1 host_interrupt_line)
        else $error("mailbox write did not raise host line");
    write_irq_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        h2c_wr && !local_bus_misc_config_reg[CFG_MBOX_IRQ_BIT] && !mbox_irq_pending_reg |=> !mbox_irq_pending_reg)
        else $error("mailbox write raised line while disabled");
    host_read_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        host_mbox_rd && !h2c_wr && !c2h_wr |=> !mbox_irq_pending_reg)
        else $error("host read left mailbox interrupt pending");
    status_h2c_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        h2c_wr || host_mbox_rd |=> local_bus_irq_status_reg[ST_H2C_BIT])
        else $error("status bit 12 not set");
    status_c2h_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        c2h_wr |=> local_bus_irq_status_reg[ST_C2H_BIT])
        else $error("status bit 13 not set");
    mask_no_status_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take_wr && hit(cpu_addr, IRQ_MASK_OFS) && !lb_rd |=> $stable(local_bus_irq_status_reg))
        else $error("mask write changed status");
    global_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !local_bus_irq_global_enable_reg && !mbox_irq_pending_reg |=> !host_interrupt_line)
        else $error("host line raised with global enable clear");
    direct_reply_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_direct_done |-> direct_access_range_write || cpu_rdata == {16'h0000, $past(direct_access_range_rdata, 2)})
        else $error("direct access reply wrong");
    direct_stall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_DIRECT) && !acc.done |=> !cpu_ready)
        else $error("direct access answered before local bus");

    // data paths, checked one edge after the access is taken
    mbox_rd_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        take_rd && hit(cpu_addr, HOST_TO_CPU_MBOX_OFS) |=> cpu_rdata == {16'h0000, $past(host_to_cpu_mailbox_reg)})
        else $error("cpu mailbox read returned wrong data");
    mbox_wr_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        h2c_wr |=> {16'h0000, host_to_cpu_mailbox_reg} == ($past(cpu_wdata) & 32'h0000ffff))
        else $error("cpu mailbox write stored wrong data");
    pending_line_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        mbox_irq_pending_reg |=> host_interrupt_line)
        else $error("pending mailbox interrupt not on host line");
    direct_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        acc.start |=> {1'b0, direct_access_range_addr, 2'b00} == ($past(cpu_addr) & 18'h1fffc))
        else $error("direct access address not taken from cpu address");
endmodule
`default_nettype wire

//--- rtl/mbox_pkg.sv
// What this block does
// - the processor reads and writes the host-to-cpu mailbox over its register port.
// - the local bus master only reads the mailbox, with a read at local bus address 8, and gets its contents.
// - a processor read of the mailbox changes no interrupt line, status bit or other state.
// - a processor mailbox write sets the pending mailbox interrupt on the host line only when misc config bit 2 is set.
// - a local bus master mailbox read clears a pending host interrupt left by a processor mailbox write.
// - host-to-cpu mailbox activity sets status bit 12.
// - the mailbox holds 16 bits in 15:0, reset to zero, with 31:16 reserved.
// - each direct access range access becomes one local bus read or write, with no DMA.
// - direct access local bus address 14:0 comes from processor address 16:2.
// - only the low 16 data bits of a direct access are carried; the upper bits are not valid.
// - the direct access range starts at 0x20000 in the internal map and has no other window.
// - cpu-to-host mailbox activity sets status bit 13.
// - the mask only selects which status bits reach the interrupt and never sets or clears status.
// - a global enable bit, reset to zero, gates the masked status interrupt.
package mbox_pkg;
    // ----------------------------------------
    // register map, byte addresses
    // ----------------------------------------
    localparam logic [17:0] IRQ_STATUS_OFS = 18'h00500;
    localparam logic [17:0] IRQ_MASK_OFS = 18'h00504;
    localparam logic [17:0] IRQ_GLOBAL_EN_OFS = 18'h00508;
    localparam logic [17:0] MISC_CONFIG_OFS = 18'h00510;
    localparam logic [17:0] CPU_TO_HOST_MBOX_OFS = 18'h00600;
    localparam logic [17:0] HOST_TO_CPU_MBOX_OFS = 18'h00604;
    localparam logic [17:0] DIRECT_RANGE_OFS = 18'h20000;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int MBOX_W = 16;
    localparam int IRQ_W = 19;
    localparam int LB_ADDR_W = 15;
    localparam int CFG_MBOX_IRQ_BIT = 2;
    localparam int ST_H2C_BIT = 12;
    localparam int ST_C2H_BIT = 13;
    localparam int DIRECT_SEL_BIT = 17;
    localparam logic [LB_ADDR_W-1:0] LB_MBOX_ADDR = 15'h0008;
    localparam logic [MBOX_W-1:0] MBOX_RESET = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 19'h00000;
    localparam logic [31:0] MISC_CONFIG_RESET = 32'h00000000;
    // ----------------------------------------
    // processor port states
    // ----------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_DIRECT, ST_REPLY} port_state_t;
endpackage

//--- verif/local_bus_mailbox_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module local_bus_mailbox_tb_top;
    import mbox_pkg::*;
    logic core_clk, rst_n, cpu_req, cpu_write, cpu_ready, lb_rd, host_interrupt_line;
    logic direct_access_range_req, direct_access_range_write, direct_access_range_ack, seen_write;
    logic [17:0] cpu_addr;
    logic [31:0] cpu_wdata, cpu_rdata, rd_val;
    logic [LB_ADDR_W-1:0] lb_addr, direct_access_range_addr, seen_addr;
    logic [MBOX_W-1:0] lb_rd_data, direct_access_range_wdata, direct_access_range_rdata, seen_wdata;
    logic [3:0] wait_cycles;
    logic [7:0] n_cycles, n0;
    int n_mismatch, comparisons, waited, cycle;
    local_bus_mailbox local_bus_mailbox_inst (.core_clk(core_clk), .rst_n(rst_n), .cpu_req(cpu_req),
        .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready),
        .cpu_rdata(cpu_rdata), .lb_rd(lb_rd), .lb_addr(lb_addr), .lb_rd_data(lb_rd_data),
        .direct_access_range_req(direct_access_range_req), .direct_access_range_write(direct_access_range_write), .direct_access_range_addr(direct_access_range_addr),
        .direct_access_range_wdata(direct_access_range_wdata), .direct_access_range_ack(direct_access_range_ack), .direct_access_range_rdata(direct_access_range_rdata),
        .host_interrupt_line(host_interrupt_line));
    pio_slave_model pio_slave_model_inst (.core_clk(core_clk), .rst_n(rst_n), .direct_access_range_req(direct_access_range_req),
        .direct_access_range_write(direct_access_range_write), .direct_access_range_addr(direct_access_range_addr), .direct_access_range_wdata(direct_access_range_wdata),
        .direct_access_range_ack(direct_access_range_ack), .direct_access_range_rdata(direct_access_range_rdata), .wait_cycles(wait_cycles),
        .seen_addr(seen_addr), .seen_wdata(seen_wdata), .seen_write(seen_write), .n_cycles(n_cycles));
    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // whole run is well under a thousand cycles, so this only trips on a hang
    always @(posedge core_clk) begin
        cycle++;
        if (cycle == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request changes at falling edges; dropped in the ready cycle so it is not taken twice
    task automatic cpu_acc(input logic wr, input logic [17:0] addr, input logic [31:0] wd);
        waited = 0;
        @(negedge core_clk);
        cpu_req = 1'b1;
        cpu_write = wr;
        cpu_addr = addr;
        cpu_wdata = wd;
        do begin
            @(negedge core_clk);
            waited++;
        end while (cpu_ready !== 1'b1 && waited < 40);
        check({31'h0, cpu_ready}, 32'h1);
        rd_val = cpu_rdata;
        cpu_req = 1'b0;
    endtask
    task automatic wr(input logic [17:0] addr, input logic [31:0] wd);
        cpu_acc(1'b1, addr, wd);
    endtask
    task automatic rdchk(input logic [17:0] addr, input logic [31:0] exp);
        cpu_acc(1'b0, addr, 32'hffffffff);
        check(rd_val, exp);
    endtask
    task automatic lb_read(input logic [LB_ADDR_W-1:0] addr, input logic [MBOX_W-1:0] exp);
        @(negedge core_clk);
        lb_rd = 1'b1;
        lb_addr = addr;
        @(negedge core_clk);
        lb_rd = 1'b0;
        lb_addr = ~addr;
        check({16'h0, lb_rd_data}, {16'h0, exp});
    endtask
    task automatic line_is(input logic exp);
        repeat (3) @(negedge core_clk);
        check({31'h0, host_interrupt_line}, {31'h0, exp});
    endtask
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        cpu_req = 1'b0;
        cpu_write = 1'b0;
        cpu_addr = 18'h00000;
        cpu_wdata = 32'h00000000;
        lb_rd = 1'b0;
        lb_addr = 15'h0000;
        wait_cycles = 4'h0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        rdchk(HOST_TO_CPU_MBOX_OFS, 32'h0);
        rdchk(IRQ_GLOBAL_EN_OFS, 32'h0);
        rdchk(IRQ_STATUS_OFS, 32'h0);
        $display("test reset done");
        wr(HOST_TO_CPU_MBOX_OFS, 32'hdeadbeef);
        rdchk(HOST_TO_CPU_MBOX_OFS, 32'h0000beef);
        rdchk(IRQ_STATUS_OFS, 32'h00001000);
        line_is(1'b0);
        wr(IRQ_STATUS_OFS, 32'hffffffff);
        rdchk(HOST_TO_CPU_MBOX_OFS, 32'h0000beef);
        rdchk(IRQ_STATUS_OFS, 32'h0);
        line_is(1'b0);
        $display("test mailbox done");
        wr(MISC_CONFIG_OFS, 32'h00000004);
        wr(CPU_TO_HOST_MBOX_OFS, 32'h00001234);
        line_is(1'b1);
        rdchk(IRQ_STATUS_OFS, 32'h00002000);
        lb_read(LB_MBOX_ADDR, 16'hbeef);
        line_is(1'b0);
        lb_read(15'h0009, 16'h0000);
        rdchk(IRQ_STATUS_OFS, 32'h00003000);
        wr(HOST_TO_CPU_MBOX_OFS, 32'h0000c3c3);
        line_is(1'b1);
        lb_read(LB_MBOX_ADDR, 16'hc3c3);
        line_is(1'b0);
        wr(MISC_CONFIG_OFS, 32'h0);
        wr(IRQ_STATUS_OFS, 32'hffffffff);
        $display("test host interrupt done");
        // status source set while the global enable is still off
        wr(IRQ_MASK_OFS, 32'h00001000);
        wr(HOST_TO_CPU_MBOX_OFS, 32'h00005a5a);
        line_is(1'b0);
        wr(IRQ_GLOBAL_EN_OFS, 32'h1);
        line_is(1'b1);
        wr(IRQ_MASK_OFS, 32'h0);
        line_is(1'b0);
        rdchk(IRQ_STATUS_OFS, 32'h00001000);
        wr(IRQ_STATUS_OFS, 32'hffffffff);
        wr(IRQ_GLOBAL_EN_OFS, 32'h0);
        wr(18'h00700, 32'hffffffff);
        rdchk(18'h00700, 32'h0);
        $display("test mask and enable done");
        // a low word and the highest word of the range, fast and slow slave
        for (int i = 0; i < 2; i++) begin
            wait_cycles = (i == 0) ? 4'h0 : 4'h5;
            n0 = n_cycles;
            wr((i == 0) ? 18'h20004 : 18'h3fffc, (i == 0) ? 32'hffff1357 : 32'h0000abcd);
            check({17'h0, seen_addr}, (i == 0) ? 32'h1 : 32'h7fff);
            check({16'h0, seen_wdata}, (i == 0) ? 32'h1357 : 32'habcd);
            check({31'h0, seen_write}, 32'h1);
            check({24'h0, n_cycles}, {24'h0, n0 + 8'h01});
            check(waited, wait_cycles + 4);
            rdchk((i == 0) ? 18'h20004 : 18'h3fffc, (i == 0) ? 32'h1357 : 32'habcd);
            check({31'h0, seen_write}, 32'h0);
            check({24'h0, n_cycles}, {24'h0, n0 + 8'h02});
        end
        $display("test direct access done");
        test_done();
    end
endmodule
`default_nettype wire

//--- verif/pio_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module pio_slave_model
    import mbox_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // local bus cycle from the design
    input wire logic direct_access_range_req,
    input wire logic direct_access_range_write,
    input wire logic [LB_ADDR_W-1:0] direct_access_range_addr,
    input wire logic [MBOX_W-1:0] direct_access_range_wdata,
    output logic direct_access_range_ack,
    output logic [MBOX_W-1:0] direct_access_range_rdata,
    // bench settings and observations
    input wire logic [3:0] wait_cycles,
    output logic [LB_ADDR_W-1:0] seen_addr,
    output logic [MBOX_W-1:0] seen_wdata,
    output logic seen_write,
    output logic [7:0] n_cycles
);
    logic [MBOX_W-1:0] mem [16];
    logic [3:0] wait_cnt;
    // ----------------------------------------
    // slave timing and storage
    // ----------------------------------------
    // ack is a single pulse; outside it the data lines toggle so stale data never passes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            direct_access_range_ack <= 1'b0;
            direct_access_range_rdata <= 16'h0000;
            wait_cnt <= 4'h0;
            seen_addr <= '0;
            seen_wdata <= 16'h0000;
            seen_write <= 1'b0;
            n_cycles <= 8'h00;
        end else if (direct_access_range_ack) begin
            direct_access_range_ack <= 1'b0;
            direct_access_range_rdata <= ~direct_access_range_rdata;
        end else if (direct_access_range_req && wait_cnt == wait_cycles) begin
            direct_access_range_ack <= 1'b1;
            wait_cnt <= 4'h0;
            n_cycles <= n_cycles + 8'h01;
            seen_addr <= direct_access_range_addr;
            seen_wdata <= direct_access_range_wdata;
            seen_write <= direct_access_range_write;
            if (direct_access_range_write) begin
                mem[direct_access_range_addr[3:0]] <= direct_access_range_wdata;
                direct_access_range_rdata <= ~direct_access_range_rdata;
            end else begin
                direct_access_range_rdata <= mem[direct_access_range_addr[3:0]];
            end
        end else begin
            if (direct_access_range_req) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
            direct_access_range_rdata <= ~direct_access_range_rdata;
        end
    end
endmodule
`default_nettype wire
